// [common/spd_defines.svh]
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH

// register indices, byte address is four times the index
`define SPD_IDX_STATUS 8'h00
`define SPD_IDX_CONFIG 8'h01

// status field positions
`define SPD_ST_OUT_LOW 0
`define SPD_ST_PD_OC 1
`define SPD_ST_PWR_BAD 2
`define SPD_ST_OVERLOAD 3
`define SPD_ST_OVERTEMP 4

// config field positions and reset value
`define SPD_CF_VSEL_LSB 0
`define SPD_CF_VSEL_MSB 2
`define SPD_CF_COMP 3
`define SPD_CF_ENABLE 4
`define SPD_CF_WIDTH 5
`define SPD_CFG_RESET 5'h00

// serial slave address choices, values arbitrary
`define SPD_ADDR_LOW 7'h10
`define SPD_ADDR_HIGH 7'h11

// timing: clock period, timebase tick and intervals
`define SPD_CLK_NS 40
`define SPD_MS_NS 1000000
`define SPD_TICK_NS 1000000
`define SPD_SS_MS 5
`define SPD_DEGLITCH_MS 10
`define SPD_TRUN_MS 90
`define SPD_TOFF_MS 900

`endif

// [common/spd_pkg.sv]
package spd_pkg;

    // overload timer states, one-hot
    typedef enum logic [2:0] {
        SPD_OL_IDLE = 3'b001,
        SPD_OL_RUN  = 3'b010,
        SPD_OL_OFF  = 3'b100
    } spd_ol_e;

    typedef logic [31:0] spd_word_t;

endpackage

// [rtl/spd_core.sv]
`timescale 1ns/1ps
`include "spd_defines.svh"

module spd_core import spd_pkg::*; #(
    parameter int unsigned TICK_CYC = (`SPD_TICK_NS + `SPD_CLK_NS - 1) / `SPD_CLK_NS
) (
    // clock and power-up reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog monitors and address select, asynchronous levels
    input wire logic supply_lockout,
    input wire logic below_low_power_diag_threshold,
    input wire logic vout_below_window,
    input wire logic pulldown_overcurrent,
    input wire logic overload_detect,
    input wire logic overtemp_detect,
    input wire logic addr_select,
    // power stage controls and serial slave address
    output logic boost_en,
    output logic ldo_en,
    output logic [2:0] vout_sel,
    output logic comp_ceramic,
    output logic [2:0] ss_step,
    output logic [6:0] slave_addr
);

    localparam int unsigned NSYNC = 7;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
    localparam logic [9:0] SS_T = 10'(`SPD_SS_MS * `SPD_MS_NS / `SPD_TICK_NS);
    // least time: round up, then flag only when exceeded
    localparam logic [9:0] DEG_T = 10'((`SPD_DEGLITCH_MS * `SPD_MS_NS + `SPD_TICK_NS - 1) / `SPD_TICK_NS);
    localparam logic [9:0] RUN_T = 10'(`SPD_TRUN_MS * `SPD_MS_NS / `SPD_TICK_NS);
    localparam logic [9:0] OFF_T = 10'(`SPD_TOFF_MS * `SPD_MS_NS / `SPD_TICK_NS);

    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    logic lock_s;
    logic lowpwr_s;
    logic vlow_s;
    logic pdoc_s;
    logic ol_s;
    logic ot_s;
    logic addr_s;
    logic [15:0] pre_q;
    logic tick_q;
    logic [`SPD_CF_WIDTH-1:0] cfg_q;
    logic [2:0] ss_q;
    logic boost_q;
    logic ldo_q;
    logic pwr_ok;
    logic ss_done;
    spd_ol_e ol_q;
    logic ol_seen_q;
    logic [9:0] ol_cnt_q;
    logic [9:0] deg_q;
    logic pd_flag_q;
    logic out_low_q;
    logic [2:0] latch_q;
    logic [2:0] armed_q;
    logic [2:0] cause;
    logic [4:0] status;
    logic setup;
    logic done;
    logic hit_stat;
    logic hit_cfg;
    logic stat_rd;

    assign async_in = {addr_select, overtemp_detect, overload_detect, pulldown_overcurrent,
                       vout_below_window, below_low_power_diag_threshold, supply_lockout};

    // two-stage synchronisers, the first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= async_in[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    assign {addr_s, ot_s, ol_s, pdoc_s, vlow_s, lowpwr_s, lock_s} = sync_q;

    // slow timebase strobe, one per millisecond
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (pre_q == TICK_LAST) begin
            pre_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            pre_q <= pre_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // apb decode; zero-wait access, pready rises in the first access cycle
    assign setup = psel & ~penable;
    assign done = psel & penable & pready;
    // byte address is the index times four, cut to the bus width
    assign hit_stat = (paddr == 8'({`SPD_IDX_STATUS, 2'b00}));
    assign hit_cfg = (paddr == 8'({`SPD_IDX_CONFIG, 2'b00}));
    assign stat_rd = done & ~pwrite & hit_stat & ~lock_s;

    assign status[`SPD_ST_OUT_LOW] = out_low_q;
    assign status[`SPD_ST_PD_OC] = pd_flag_q;
    assign status[`SPD_ST_PWR_BAD] = latch_q[0];
    assign status[`SPD_ST_OVERLOAD] = latch_q[1];
    assign status[`SPD_ST_OVERTEMP] = latch_q[2];

    // bus answer; interface state clears at power-up reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup) begin
            pready <= 1'b1;
            // lockout refuses everything, so software sees the error
            pslverr <= lock_s | ~(hit_stat | hit_cfg);
            if (hit_stat & ~lock_s) begin
                prdata <= {27'h0000000, status};
            end else if (hit_cfg & ~lock_s) begin
                prdata <= {27'h0000000, cfg_q};
            end else begin
                prdata <= 32'h00000000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // config register; held at zero under lockout
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `SPD_CFG_RESET;
        end else if (lock_s) begin
            cfg_q <= `SPD_CFG_RESET;
        end else if (done & pwrite & hit_cfg) begin
            cfg_q <= pwdata[`SPD_CF_WIDTH-1:0];
        end
    end

    // power gating: lockout and heat override software
    assign pwr_ok = cfg_q[`SPD_CF_ENABLE] & ~lock_s & ~ot_s;
    assign ss_done = (ss_q == SS_T[2:0]);

    // soft start counts ticks while the converter runs, restarts when it stops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ss_q <= 3'h0;
        end else if (!boost_q) begin
            ss_q <= 3'h0;
        end else if (tick_q && !ss_done) begin
            ss_q <= ss_q + 3'h1;
        end
    end

    // stage enables; regulator waits for the ramp and for the off interval
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_q <= 1'b0;
            ldo_q <= 1'b0;
        end else begin
            boost_q <= pwr_ok;
            ldo_q <= pwr_ok & boost_q & ss_done & (ol_q != SPD_OL_OFF);
        end
    end

    // overload cycling timer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ol_q <= SPD_OL_IDLE;
            ol_seen_q <= 1'b0;
            ol_cnt_q <= 10'h000;
        end else if (!pwr_ok) begin
            ol_q <= SPD_OL_IDLE;
            ol_seen_q <= 1'b0;
            ol_cnt_q <= 10'h000;
        end else begin
            case (ol_q)
                SPD_OL_IDLE: begin
                    if (ldo_q && ol_s) begin
                        ol_q <= SPD_OL_RUN;
                        ol_seen_q <= 1'b1;
                        ol_cnt_q <= 10'h000;
                    end
                end
                SPD_OL_RUN: begin
                    if (ol_s) begin
                        ol_seen_q <= 1'b1;
                    end
                    if (tick_q) begin
                        if (ol_cnt_q == RUN_T - 10'h001) begin
                            ol_cnt_q <= 10'h000;
                            // a clean full interval ends the cycling
                            ol_q <= (ol_seen_q | ol_s) ? SPD_OL_OFF : SPD_OL_IDLE;
                        end else begin
                            ol_cnt_q <= ol_cnt_q + 10'h001;
                        end
                    end
                end
                SPD_OL_OFF: begin
                    if (tick_q) begin
                        if (ol_cnt_q == OFF_T - 10'h001) begin
                            ol_cnt_q <= 10'h000;
                            ol_seen_q <= 1'b0;
                            ol_q <= SPD_OL_RUN;
                        end else begin
                            ol_cnt_q <= ol_cnt_q + 10'h001;
                        end
                    end
                end
                default: begin
                    ol_q <= SPD_OL_IDLE;
                    ol_seen_q <= 1'b0;
                    ol_cnt_q <= 10'h000;
                end
            endcase
        end
    end

    // pull-down overcurrent deglitch, counted in ticks of persistence
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            deg_q <= 10'h000;
            pd_flag_q <= 1'b0;
        end else if (!pdoc_s) begin
            deg_q <= 10'h000;
            pd_flag_q <= 1'b0;
        end else begin
            if (tick_q && deg_q <= DEG_T) begin
                deg_q <= deg_q + 10'h001;
            end
            if (deg_q > DEG_T) begin
                pd_flag_q <= 1'b1;
            end
        end
    end

    // output-low diagnostic is live, gated by the regulator enable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_low_q <= 1'b0;
        end else begin
            out_low_q <= ldo_q & vlow_s;
        end
    end

    // latched flags: a read arms the clear, which happens once the cause is gone;
    // a cause present in the clearing cycle keeps the flag set
    assign cause = {ot_s, ol_q != SPD_OL_IDLE, lowpwr_s};
    generate
        for (gi = 0; gi < 3; gi++) begin : g_latch
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    latch_q[gi] <= 1'b0;
                    armed_q[gi] <= 1'b0;
                end else if (cause[gi]) begin
                    latch_q[gi] <= 1'b1;
                    armed_q[gi] <= armed_q[gi] | (stat_rd & latch_q[gi]);
                end else if (armed_q[gi] | stat_rd) begin
                    latch_q[gi] <= 1'b0;
                    armed_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // outputs to the power stages and the serial front end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_addr <= `SPD_ADDR_LOW;
        end else begin
            slave_addr <= addr_s ? `SPD_ADDR_HIGH : `SPD_ADDR_LOW;
        end
    end

    assign boost_en = boost_q;
    assign ldo_en = ldo_q;
    assign vout_sel = cfg_q[`SPD_CF_VSEL_MSB:`SPD_CF_VSEL_LSB];
    assign comp_ceramic = cfg_q[`SPD_CF_COMP];
    assign ss_step = ss_q;

    // checks
    lockout_cfg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lock_s |=> cfg_q == `SPD_CFG_RESET)
        else $error("config not held at zero under lockout");

    lockout_power_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lock_s |=> !boost_q ##1 !ldo_q)
        else $error("power stage active under lockout");

    overtemp_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ot_s |=> !boost_q && latch_q[2])
        else $error("overtemp did not shut down or flag");

    ol_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ol_q == SPD_OL_IDLE && pwr_ok && ldo_q && ol_s) |=> ol_q == SPD_OL_RUN ##1 latch_q[1])
        else $error("overload did not start cycling with flag");

    ol_off_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ol_q == SPD_OL_OFF && pwr_ok && tick_q && ol_cnt_q == OFF_T - 10'h001)
        |=> ol_q == SPD_OL_RUN && ol_cnt_q == 10'h000)
        else $error("off interval did not resume output");

    ol_off_dark_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ol_q == SPD_OL_OFF) |=> !ldo_q)
        else $error("regulator enabled during off interval");

    flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (latch_q[1] && !stat_rd && !armed_q[1]) |=> latch_q[1])
        else $error("overload flag dropped without a read");

    pd_deglitch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(pd_flag_q) |-> $past(deg_q) > DEG_T && $past(pdoc_s))
        else $error("pull-down flag set before deglitch time");

    out_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ldo_q && vlow_s) |=> out_low_q ##0 status[`SPD_ST_OUT_LOW])
        else $error("output-low flag missed");

    ss_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!ss_done) |=> !ldo_q)
        else $error("regulator enabled before soft start ends");

    apb_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        setup |=> pready ##1 !pready)
        else $error("apb answer not in first access cycle");

    pwr_bad_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lowpwr_s |=> latch_q[0])
        else $error("power-not-good flag not set at low input");

    lock_refuse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (setup && lock_s) |=> pslverr && prdata == 32'h00000000)
        else $error("bus access not refused under lockout");

endmodule

// [tb/spd_host_model.sv]
`timescale 1ns/1ps

// host side of the register bus, one transfer at a time
module spd_host_model (
    // clock
    input wire logic sys_clk,
    // request to the block
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // answer from the block
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // setup, then access held until pready; config writes by the host land here
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic to);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        err = pslverr;
        to = (pready !== 1'b1);
        // scramble released lines so a stale address never looks valid
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`include "spd_defines.svh"

module tb import spd_pkg::*;;
    localparam logic [7:0] st_a = 8'(`SPD_IDX_STATUS * 4);
    localparam logic [7:0] cfg_a = 8'(`SPD_IDX_CONFIG * 4);
    localparam int toff = `SPD_TOFF_MS * 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic supply_lockout = 1'b0;
    logic below_low_power_diag_threshold = 1'b0;
    logic vout_below_window = 1'b0;
    logic pulldown_overcurrent = 1'b0;
    logic overload_detect = 1'b0;
    logic overtemp_detect = 1'b0;
    logic addr_select = 1'b0;
    logic boost_en, ldo_en, comp_ceramic;
    logic [2:0] vout_sel, ss_step;
    logic [6:0] slave_addr;
    int fails = 0;
    int checks = 0;
    int n;
    typedef struct {logic [4:0] cfg; logic [2:0] vs; logic cp;} spd_row_s;
    // config word beside the level and compensation it should drive
    spd_row_s rows [8] = '{'{5'h00, 3'h0, 1'h0}, '{5'h09, 3'h1, 1'h1}, '{5'h02, 3'h2, 1'h0},
        '{5'h0B, 3'h3, 1'h1}, '{5'h04, 3'h4, 1'h0}, '{5'h0D, 3'h5, 1'h1}, '{5'h06, 3'h6, 1'h0},
        '{5'h0F, 3'h7, 1'h1}};

    always #20 sys_clk = ~sys_clk;

    // small tick divider keeps the long protection intervals affordable
    spd_core #(.TICK_CYC(4)) spd_core_inst (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_lockout(supply_lockout),
        .below_low_power_diag_threshold(below_low_power_diag_threshold),
        .vout_below_window(vout_below_window), .pulldown_overcurrent(pulldown_overcurrent),
        .overload_detect(overload_detect), .overtemp_detect(overtemp_detect),
        .addr_select(addr_select), .boost_en(boost_en), .ldo_en(ldo_en), .vout_sel(vout_sel),
        .comp_ceramic(comp_ceramic), .ss_step(ss_step), .slave_addr(slave_addr));

    spd_host_model spd_host_model_inst (.sys_clk(sys_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic close_out();
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input spd_word_t seen, input spd_word_t exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // one bus transfer with its error response compared, and its data too on reads
    task automatic xf(input logic w, input logic [7:0] a, input spd_word_t d, input logic eerr);
        spd_word_t rd;
        logic err, to;
        spd_host_model_inst.xfer(w, a, d, rd, err, to);
        if (to) begin
            fails++;
            close_out();
        end
        if (!w) chk("rdata", rd, d);
        chk("slverr", spd_word_t'(err), spd_word_t'(eerr));
    endtask

    // bounded wait for the regulator enable to reach a level
    task automatic wait_ldo(input logic v, input int mx);
        n = 0;
        while (ldo_en !== v) begin
            @(posedge sys_clk);
            n++;
            if (n > mx) begin
                fails++;
                close_out();
            end
        end
    endtask

    initial begin
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        chk("slave_addr", slave_addr, `SPD_ADDR_LOW);
        chk("outputs", {boost_en, ldo_en, vout_sel, comp_ceramic, ss_step}, 32'h0);
        xf(1'b0, st_a, 32'h0, 1'b0);
        foreach (rows[i]) begin
            xf(1'b1, cfg_a, 32'(rows[i].cfg), 1'b0);
            cyc(2);
            chk("vout_sel", vout_sel, rows[i].vs);
            chk("comp", comp_ceramic, rows[i].cp);
            xf(1'b0, cfg_a, 32'(rows[i].cfg), 1'b0);
        end
        // status ignores writes; a hole in the map answers with an error
        xf(1'b1, st_a, 32'h1F, 1'b0);
        xf(1'b0, st_a, 32'h0, 1'b0);
        xf(1'b1, 8'h08, 32'h1F, 1'b1);
        xf(1'b0, 8'h08, 32'h0, 1'b1);
        addr_select <= 1'b1;
        cyc(6);
        chk("slave_addr", slave_addr, `SPD_ADDR_HIGH);
        // enable: converter first, regulator only once the ramp is done
        xf(1'b1, cfg_a, 32'h10, 1'b0);
        cyc(8);
        chk("boost_en", boost_en, 32'h1);
        chk("ldo_early", ldo_en, 32'h0);
        wait_ldo(1'b1, 40);
        chk("ss_step", ss_step, `SPD_SS_MS);
        vout_below_window <= 1'b1;
        cyc(6);
        xf(1'b0, st_a, 32'h1 << `SPD_ST_OUT_LOW, 1'b0);
        vout_below_window <= 1'b0;
        cyc(6);
        xf(1'b0, st_a, 32'h0, 1'b0);
        // short overcurrent stays hidden, a lasting one shows
        pulldown_overcurrent <= 1'b1;
        cyc(30);
        xf(1'b0, st_a, 32'h0, 1'b0);
        cyc(20);
        xf(1'b0, st_a, 32'h1 << `SPD_ST_PD_OC, 1'b0);
        pulldown_overcurrent <= 1'b0;
        cyc(6);
        xf(1'b0, st_a, 32'h0, 1'b0);
        below_low_power_diag_threshold <= 1'b1;
        cyc(6);
        below_low_power_diag_threshold <= 1'b0;
        cyc(6);
        xf(1'b0, st_a, 32'h1 << `SPD_ST_PWR_BAD, 1'b0);
        xf(1'b0, st_a, 32'h0, 1'b0);
        // no read while hot, so the first read after cooling must still see the flag
        overtemp_detect <= 1'b1;
        cyc(6);
        chk("hot_power", {boost_en, ldo_en}, 32'h0);
        overtemp_detect <= 1'b0;
        cyc(6);
        chk("cool_boost", boost_en, 32'h1);
        xf(1'b0, st_a, 32'h1 << `SPD_ST_OVERTEMP, 1'b0);
        xf(1'b0, st_a, 32'h0, 1'b0);
        wait_ldo(1'b1, 40);
        // overload: run interval, off interval, then a clean run
        overload_detect <= 1'b1;
        cyc(340);
        chk("ldo_run", ldo_en, 32'h1);
        wait_ldo(1'b0, 40);
        cyc(100);
        overload_detect <= 1'b0;
        wait_ldo(1'b1, toff + 40);
        chk("off_len", spd_word_t'(n + 100 >= toff - 8 && n + 100 <= toff + 4), 32'h1);
        cyc(`SPD_TRUN_MS * 4 + 40);
        chk("ldo_normal", ldo_en, 32'h1);
        xf(1'b0, st_a, 32'h1 << `SPD_ST_OVERLOAD, 1'b0);
        xf(1'b0, st_a, 32'h0, 1'b0);
        // lockout wipes the config and refuses the bus
        xf(1'b1, cfg_a, 32'h1F, 1'b0);
        supply_lockout <= 1'b1;
        cyc(6);
        chk("lock_out", {boost_en, ldo_en, vout_sel, comp_ceramic}, 32'h0);
        xf(1'b1, cfg_a, 32'h1A, 1'b1);
        xf(1'b0, st_a, 32'h0, 1'b1);
        supply_lockout <= 1'b0;
        cyc(6);
        xf(1'b0, cfg_a, 32'h0, 1'b0);
        xf(1'b1, cfg_a, 32'h0B, 1'b0);
        xf(1'b0, cfg_a, 32'h0B, 1'b0);
        // a second power-up reset must clear the interface and the config
        rst_n <= 1'b0;
        cyc(2);
        chk("reset_addr", slave_addr, `SPD_ADDR_LOW);
        chk("reset_out", {boost_en, ldo_en, vout_sel, comp_ceramic}, 32'h0);
        rst_n <= 1'b1;
        cyc(1);
        xf(1'b0, cfg_a, 32'h0, 1'b0);
        close_out();
    end
endmodule
